// file: hdl/cafm_filter_cmp.sv
`timescale 1ns/100ps
`include "cafm_params.svh"

module cafm_filter_cmp
  import cafm_pkg::*;
(
  input  wire logic [15:0]     stdReg,
  input  wire logic [15:0]     extReg,
  input  wire cafm_msksrc_t    maskSrc,
  input  wire cafm_mask_t [2:0] accMask,
  input  wire cafm_rxid_t      rxId,
  output logic                 hit
);

  cafm_mask_t  selMask;
  logic        srcOk;
  logic        typeOk;
  logic        stdOk;
  logic        extOk;
  logic [17:0] fltExt;

  always_comb
  begin
    srcOk   = 1'b1;
    selMask = accMask[0];
    unique case (maskSrc)
      CAFM_MASK0: selMask = accMask[0];                                 // [R09]
      CAFM_MASK1: selMask = accMask[1];                                 // [R09]
      CAFM_MASK2: selMask = accMask[2];                                 // [R09]
      CAFM_MASK_RSVD:
      begin
        // Reserved source never matches, so a stray code cannot open the filter
        srcOk   = 1'b0;                                                 // [R09]
        selMask = accMask[0];
      end
    endcase
  end

  assign fltExt = {stdReg[`CAFM_EXTHI_MSB:`CAFM_EXTHI_LSB], extReg};    // [R05] [R06]

  // Type check only when the mask asks for it; filter type bit else ignored
  assign typeOk = !selMask.typeChk
                  || (stdReg[`CAFM_TYPE_BIT] == rxId.ext);              // [R03] [R04]

  // Mask bit zero is don't care, one takes part
  assign stdOk = ((stdReg[`CAFM_SID_MSB:`CAFM_SID_LSB] ^ rxId.std_identifier_bits)
                  & selMask.stdMask) == 11'h000;                        // [R02] [R10]

  // A standard frame carries no extended bits to compare
  assign extOk = !rxId.ext
                 || (((fltExt ^ rxId.ext_identifier_bits) & selMask.extMask) == 18'h0_0000); // [R05] [R06] [R10]

  assign hit = srcOk && typeOk && stdOk && extOk;                       // [R11]

endmodule // cafm_filter_cmp

// file: hdl/cafm_filter_match.sv
// Function
// R01 - Sixteen filters, numbered zero to fifteen, each own a standard and an extended register.
// R02 - Standard register bits fifteen to five give the value each masked received bit must equal.
// R03 - With mask type check set and filter type select set, only extended frames match.
// R04 - With type check set and type select clear only standard frames match; check clear ignores type.
// R05 - Standard register bits one and zero hold extended identifier bits seventeen and sixteen.
// R06 - The extended register holds extended identifier bits fifteen down to zero.
// R07 - Standard register bits four and two read as zero and ignore writes.
// R08 - The low mask select register gives filters seven to zero two bits each, seven on top.
// R09 - Mask source 00, 01, 10 pick masks zero, one, two; 11 is reserved.
// R10 - A mask bit of zero makes its identifier bit don't care, one makes it compared.
// R11 - A filter hits only when all masked bits agree and the type condition holds.
`timescale 1ns/100ps
`include "cafm_params.svh"

module cafm_filter_match
  import cafm_pkg::*;
#(
  parameter int NUM_FILTERS = `CAFM_MAX_FILTERS
)
(
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  // Classic Wishbone slave
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [`CAFM_ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  // Neighbouring mask registers and upper mask selection
  input  wire cafm_mask_t [2:0]      accMask,
  input  wire logic [15:0]           maskSelHigh,
  // Received identifier from the protocol engine
  input  wire logic                  rxValid,
  input  wire cafm_rxid_t            rxId,
  // Match result
  output logic [NUM_FILTERS-1:0]     matchHit,
  output logic                       matchValid,
  output logic                       matchAny,
  output logic [3:0]                 matchIndex
);

  generate
    if (NUM_FILTERS < 1 || NUM_FILTERS > `CAFM_MAX_FILTERS)
    begin : g_bad_count
      $error("cafm_filter_match: NUM_FILTERS must lie in 1..16");
    end
  endgenerate

  // Storage
  logic [15:0] fltStd_reg [NUM_FILTERS];
  logic [15:0] fltExt_reg [NUM_FILTERS];
  logic [15:0] mskSelLow_reg;
  logic [NUM_FILTERS-1:0] lastHit_reg;

  cafm_bus_t   busState_reg;
  cafm_bus_t   busState_next;
  logic [31:0] rdData_next;
  logic [NUM_FILTERS-1:0] hitNow;

  logic        busReq;
  logic        busWrite;
  logic        inFltSpan;
  logic [3:0]  fltSel;
  logic        fltExtSel;
  logic        fltValid;

  // Merge byte lanes 0 and 1 into a 16-bit register
  function automatic logic [15:0] merge16(
    input logic [15:0] oldVal,
    input logic [31:0] wrData,
    input logic [3:0]  sel
  );
    logic [15:0] res;
    res = oldVal;
    if (sel[0])
    begin
      res[7:0] = wrData[7:0];
    end
    if (sel[1])
    begin
      res[15:8] = wrData[15:8];
    end
    return res;
  endfunction

  // Mask source field of a filter
  function automatic cafm_msksrc_t maskSrcOf(
    input int          idx,
    input logic [15:0] lowSel,
    input logic [15:0] highSel
  );
    cafm_msksrc_t src;
    if (idx < `CAFM_LOW_FILTERS)
    begin
      src = cafm_msksrc_t'(lowSel[idx*`CAFM_MSK_W +: `CAFM_MSK_W]);   // [R08]
    end
    else
    begin
      src = cafm_msksrc_t'(highSel[(idx-`CAFM_LOW_FILTERS)*`CAFM_MSK_W +: `CAFM_MSK_W]);
    end
    return src;
  endfunction

  // Lowest numbered hit wins the reported index
  function automatic logic [3:0] firstHit(
    input logic [NUM_FILTERS-1:0] hits
  );
    logic [3:0] idx;
    logic       found;
    idx   = 4'h0;
    found = 1'b0;
    for (int i = 0; i < NUM_FILTERS; i++)
    begin
      if (hits[i] && !found)
      begin
        idx   = 4'(i);
        found = 1'b1;
      end
    end
    return idx;
  endfunction

  // Address decode
  assign busReq    = wb_cyc_i && wb_stb_i && (busState_reg == CAFM_BUS_IDLE);
  assign busWrite  = busReq && wb_we_i;
  assign inFltSpan = wb_adr_i < `CAFM_FLT_SPAN;
  assign fltSel    = wb_adr_i[6:3];
  assign fltExtSel = wb_adr_i[2];
  assign fltValid  = inFltSpan && (int'(fltSel) < NUM_FILTERS) && (wb_adr_i[1:0] == 2'b00);

  // Bus handshake: ack one cycle after the request, then drop
  always_comb
  begin
    busState_next = busState_reg;
    unique case (busState_reg)
      CAFM_BUS_IDLE:
      begin
        if (busReq)
        begin
          busState_next = CAFM_BUS_ACK;
        end
      end
      CAFM_BUS_ACK:
      begin
        busState_next = CAFM_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busState_reg <= CAFM_BUS_IDLE;
    end
    else
    begin
      busState_reg <= busState_next;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wb_ack_o <= 1'b0;
    end
    else
    begin
      wb_ack_o <= (busState_next == CAFM_BUS_ACK);
    end
  end

  // Read mux; unmapped addresses still ack and read zero
  always_comb
  begin
    rdData_next = 32'h0000_0000;
    if (fltValid)
    begin
      if (fltExtSel)
      begin
        rdData_next[15:0] = fltExt_reg[fltSel];                         // [R06]
      end
      else
      begin
        rdData_next[15:0] = fltStd_reg[fltSel] & `CAFM_SID_IMPL;        // [R07]
      end
    end
    else if (wb_adr_i == `CAFM_MSKSEL_OFS)
    begin
      rdData_next[15:0] = mskSelLow_reg;                                // [R08]
    end
    else if (wb_adr_i == `CAFM_STATUS_OFS)
    begin
      rdData_next[NUM_FILTERS-1:0] = lastHit_reg;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wb_dat_o <= 32'h0000_0000;
    end
    else if (busReq && !wb_we_i)
    begin
      wb_dat_o <= rdData_next;
    end
    else if (busReq)
    begin
      wb_dat_o <= 32'h0000_0000;
    end
  end

  // Filter registers, one pair per filter
  generate
    for (genvar f = 0; f < NUM_FILTERS; f++)
    begin : g_flt
      always_ff @(posedge mclk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          fltStd_reg[f] <= `CAFM_SID_RST;
        end
        else if (busWrite && fltValid && !fltExtSel && fltSel == 4'(f))
        begin
          // Unimplemented bits never store, so they cannot leak into a read
          fltStd_reg[f] <= merge16(fltStd_reg[f], wb_dat_i, wb_sel_i)
                           & `CAFM_SID_IMPL;                            // [R01] [R07]
        end
      end

      always_ff @(posedge mclk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          fltExt_reg[f] <= `CAFM_EID_RST;
        end
        else if (busWrite && fltValid && fltExtSel && fltSel == 4'(f))
        begin
          fltExt_reg[f] <= merge16(fltExt_reg[f], wb_dat_i, wb_sel_i); // [R01] [R06]
        end
      end

      cafm_filter_cmp u_cmp
      (
        .stdReg  (fltStd_reg[f]),
        .extReg  (fltExt_reg[f]),
        .maskSrc (maskSrcOf(f, mskSelLow_reg, maskSelHigh)),            // [R08]
        .accMask (accMask),
        .rxId    (rxId),
        .hit     (hitNow[f])                                            // [R11]
      );
    end
  endgenerate

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mskSelLow_reg <= `CAFM_MSKSEL_RST;
    end
    else if (busWrite && wb_adr_i == `CAFM_MSKSEL_OFS)
    begin
      mskSelLow_reg <= merge16(mskSelLow_reg, wb_dat_i, wb_sel_i);     // [R08]
    end
  end

  // Match results; registers written in the same cycle take effect next
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      matchValid <= 1'b0;
    end
    else
    begin
      matchValid <= rxValid;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      matchHit   <= '0;
      matchAny   <= 1'b0;
      matchIndex <= 4'h0;
    end
    else if (rxValid)
    begin
      matchHit   <= hitNow;                                             // [R11]
      matchAny   <= |hitNow;
      matchIndex <= firstHit(hitNow);
    end
  end

  // Last hit vector kept for software, stands until the next identifier
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lastHit_reg <= '0;
    end
    else if (rxValid)
    begin
      lastHit_reg <= hitNow;
    end
  end

endmodule // cafm_filter_match

// file: include/cafm_params.svh
`ifndef CAFM_PARAMS_SVH
`define CAFM_PARAMS_SVH

// Register map, byte addresses on the 32-bit bus
`define CAFM_ADR_W          8
`define CAFM_SID_OFS        8'h00
`define CAFM_EID_OFS        8'h04
`define CAFM_FLT_STRIDE     8'h08
`define CAFM_FLT_SPAN       8'h80
`define CAFM_MSKSEL_OFS     8'h80
`define CAFM_STATUS_OFS     8'h84

// Field positions in filter_standard_id
`define CAFM_SID_MSB        15
`define CAFM_SID_LSB        5
`define CAFM_TYPE_BIT       3
`define CAFM_EXTHI_MSB      1
`define CAFM_EXTHI_LSB      0
`define CAFM_SID_IMPL       16'hffeb

// Reset values
`define CAFM_SID_RST        16'h0000
`define CAFM_EID_RST        16'h0000
`define CAFM_MSKSEL_RST     16'h0000
`define CAFM_HIT_RST        16'h0000

// Mask selection
`define CAFM_NUM_MASKS      3
`define CAFM_MSK_W          2
`define CAFM_LOW_FILTERS    8
`define CAFM_MAX_FILTERS    16

`endif

// file: include/cafm_pkg.sv
package cafm_pkg;

  typedef struct packed
  {
    logic        ext;
    logic [10:0] std_identifier_bits;
    logic [17:0] ext_identifier_bits;
  } cafm_rxid_t;

  typedef struct packed
  {
    logic [10:0] stdMask;
    logic        typeChk;
    logic [17:0] extMask;
  } cafm_mask_t;

  typedef enum logic [1:0]
  {
    CAFM_MASK0     = 2'b00,
    CAFM_MASK1     = 2'b01,
    CAFM_MASK2     = 2'b10,
    CAFM_MASK_RSVD = 2'b11
  } cafm_msksrc_t;

  typedef enum logic
  {
    CAFM_BUS_IDLE = 1'b0,
    CAFM_BUS_ACK  = 1'b1
  } cafm_bus_t;

endpackage

// file: test/cafm_filter_match_checker.sv
`timescale 1ns/100ps
module cafm_filter_match_checker
#(
  parameter int NUM_FILTERS = 16
)
(
  input wire logic                   mclk,
  input wire logic                   rst_n,
  input wire logic                   wb_cyc_i,
  input wire logic                   wb_stb_i,
  input wire logic                   wb_we_i,
  input wire logic [7:0]             wb_adr_i,
  input wire logic [31:0]            wb_dat_o,
  input wire logic                   wb_ack_o,
  input wire logic                   rxValid,
  input wire logic [NUM_FILTERS-1:0] matchHit,
  input wire logic                   matchValid,
  input wire logic                   matchAny,
  input wire logic [3:0]             matchIndex
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_sidRead;
    wb_ack_o && !wb_we_i && wb_adr_i < 8'h80 && wb_adr_i[2:0] == 3'h0;
  endsequence
  property p_ack; s_req |=> wb_ack_o; endproperty
  property p_ackOne; wb_ack_o |=> !wb_ack_o; endproperty
  property p_datHi; wb_ack_o |-> wb_dat_o[31:16] == 16'h0000; endproperty
  property p_unimp; s_sidRead |-> !wb_dat_o[4] && !wb_dat_o[2]; endproperty
  property p_valid; rxValid |=> matchValid; endproperty
  property p_noValid; !rxValid |=> !matchValid; endproperty
  property p_hold; !rxValid |=> $stable(matchHit); endproperty
  property p_any; matchValid |-> matchAny == (|matchHit); endproperty
  property p_index;
    matchAny |-> matchHit[matchIndex] &&
      (matchHit & ((NUM_FILTERS'(1) << matchIndex) - 1'b1)) == '0;
  endproperty
  a_ack: assert property (p_ack) else $error("ack missing after request");
  a_ackOne: assert property (p_ackOne) else $error("ack longer than one cycle");
  a_datHi: assert property (p_datHi) else $error("read data upper half not zero");
  a_unimp: assert property (p_unimp) else $error("unimplemented bit reads one");
  a_valid: assert property (p_valid) else $error("match result missing");
  a_noValid: assert property (p_noValid) else $error("spurious match result");
  a_hold: assert property (p_hold) else $error("hit vector changed while idle");
  a_any: assert property (p_any) else $error("any flag disagrees with hits");
  a_index: assert property (p_index) else $error("index not lowest hit");
endmodule // cafm_filter_match_checker

bind cafm_filter_match cafm_filter_match_checker #(.NUM_FILTERS(NUM_FILTERS)) u_chk
(
  .mclk(mclk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .rxValid(rxValid), .matchHit(matchHit), .matchValid(matchValid),
  .matchAny(matchAny), .matchIndex(matchIndex)
);

// file: test/cafm_rx_model.sv
`timescale 1ns/100ps
module cafm_rx_model
  import cafm_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       send,
  input  wire cafm_rxid_t idIn,
  output logic            rxValid,
  output cafm_rxid_t      rxId
);
  // Idle lines invert each cycle so a stale identifier never looks fresh
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rxValid <= 1'b0;
      rxId    <= '0;
    end
    else
    begin
      rxValid <= send;
      rxId    <= send ? idIn : ~rxId;
    end
  end
endmodule // cafm_rx_model

// file: test/tb_cafm_filter_match.sv
`timescale 1ns/100ps
module tb_cafm_filter_match
  import cafm_pkg::*;
;
  logic mclk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, send = 0;
  logic rxValid, ack, matchValid, matchAny;
  logic [7:0] adr = '0;
  logic [3:0] sel = '0, matchIndex, bsel = 4'h3;
  logic [31:0] wdat = '0, rdat, q;
  logic [15:0] maskSelHigh = '0, r = 16'hb95f, mselS = '0, matchHit, t, hitS;
  logic [15:0] stdS [16], extS [16];
  cafm_mask_t [2:0] accMask = '0;
  cafm_rxid_t idIn = '0, rxId, id;
  int err_count = 0, cmp_count = 0, n, k;

  cafm_filter_match #(.NUM_FILTERS(16)) dut
  (
    .mclk(mclk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .accMask(accMask), .maskSelHigh(maskSelHigh), .rxValid(rxValid), .rxId(rxId),
    .matchHit(matchHit), .matchValid(matchValid), .matchAny(matchAny),
    .matchIndex(matchIndex)
  );
  cafm_rx_model peer
  (
    .mclk(mclk), .rst_n(rst_n), .send(send), .idIn(idIn), .rxValid(rxValid), .rxId(rxId)
  );

  initial
  begin
    forever #5 mclk = ~mclk;
  end

  function logic [15:0] nx();
    r = {r[14:0], r[15] ^ r[13] ^ r[12] ^ r[10]};
    return r;
  endfunction

  function logic expHit(input int f);
    logic [1:0] s;
    cafm_mask_t m;
    logic [15:0] sd;
    sd = stdS[f];
    s = f < 8 ? mselS[2*f +: 2] : maskSelHigh[2*(f-8) +: 2];
    if (s == 2'b11)
      return 1'b0;
    m = accMask[s];
    return (((sd[15:5] ^ idIn.std_identifier_bits) & m.stdMask) == 11'h0) &&
      (!m.typeChk || sd[3] == idIn.ext) &&
      (!idIn.ext || ((({sd[1:0], extS[f]} ^ idIn.ext_identifier_bits) & m.extMask) == 18'h0));
  endfunction

  task end_of_test;
    $display("Counts: %0d compares, %0d mismatches", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  task wait_for(input int i);
    if (i >= 20)
    begin
      err_count++;
      $display("MISMATCH t=%0t wait ran out", $time);
      end_of_test;
    end
  endtask

  // Single classic cycle; released only after ack is seen at an edge
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= bsel;
    i = 0;
    do
    begin
      @(posedge mclk);
      i++;
    end
    while (ack !== 1'b1 && i < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    wait_for(i);
  endtask

  task rx();
    int i;
    logic [15:0] e;
    logic [3:0] x;
    @(posedge mclk);
    send <= 1'b1;
    idIn <= id;
    @(posedge mclk);
    send <= 1'b0;
    i = 0;
    do
    begin
      @(posedge mclk);
      i++;
    end
    while (matchValid !== 1'b1 && i < 20);
    wait_for(i);
    x = 4'h0;
    for (int f = 15; f >= 0; f--)
    begin
      e[f] = expHit(f);
      if (e[f])
        x = 4'(f);
    end
    hitS = e;
    chk(32'(matchHit), 32'(e));
    chk(32'(matchAny), 32'(|e));
    chk(32'(matchIndex), 32'(x));
  endtask

  initial
  begin
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    for (k = 0; k < 35; k++)
    begin
      wb(1'b0, 8'(4*k), 32'h0);
      chk(q, 32'h0);
    end
    $display("test reset values done");
    wb(1'b1, 8'h00, 32'hffff_ffff);
    wb(1'b0, 8'h00, 32'h0);
    chk(q, 32'h0000_ffeb);
    wb(1'b1, 8'h88, 32'hffff_ffff);
    wb(1'b0, 8'h88, 32'h0);
    chk(q, 32'h0);
    // Byte lanes land one at a time in the extended register of filter one
    bsel = 4'h1;
    wb(1'b1, 8'h0c, 32'h0000_1234);
    bsel = 4'h2;
    wb(1'b1, 8'h0c, 32'h0000_abcd);
    bsel = 4'h3;
    wb(1'b0, 8'h0c, 32'h0);
    chk(q, 32'h0000_ab34);
    $display("test register access done");
    for (n = 0; n < 300; n++)
    begin
      if (n % 30 == 0)
      begin
        for (int f = 0; f < 16; f++)
        begin
          t = nx();
          stdS[f] = t & 16'hffeb;
          extS[f] = nx();
          wb(1'b1, 8'(8*f), {16'h0, t});
          wb(1'b1, 8'(8*f+4), {16'h0, extS[f]});
        end
        // Read back after all writes, so aliasing between filters shows up
        for (int f = 0; f < 16; f++)
        begin
          wb(1'b0, 8'(8*f), 32'h0);
          chk(q, {16'h0, stdS[f]});
          wb(1'b0, 8'(8*f+4), 32'h0);
          chk(q, {16'h0, extS[f]});
        end
        mselS = nx();
        wb(1'b1, 8'h80, {16'h0, mselS});
        wb(1'b0, 8'h80, 32'h0);
        chk(q, {16'h0, mselS});
        for (int m = 0; m < 3; m++)
          accMask[m] <= 30'({nx(), nx()} & {nx(), nx()});
        maskSelHigh <= nx();
      end
      t = nx();
      k = int'(t[3:0]);
      id = {t[4], stdS[k][15:5], stdS[k][1:0], extS[k]};
      if (t[6:5] == 2'b00)
        id = 30'({nx(), nx()});
      rx();
      if (n % 30 == 29)
      begin
        wb(1'b0, 8'h84, 32'h0);
        chk(q, {16'h0, hitS});
      end
    end
    $display("test random matching done");
    end_of_test;
  end
endmodule // tb_cafm_filter_match
